/* hw/crs_scaler.sv */
// Purpose: qualify and commit cell resistance, near-empty resistance scaling
// Assumes: measurement and gauge inputs come from logic on hclk
// Notes:   sec_cycles shortens the one-second tick for simulation
//
// The implementer's own choice: the AHB-Lite interface to the registers.

// Notes on behaviour
// (RULE_01) keep measurements live, commit only when qualified
// (RULE_02) need current over capacity/10 or enough drop
// (RULE_03) discharge must exceed 500 seconds
// (RULE_04) inhibit bit zero and gauging enabled
// (RULE_05) weighted blend of old and new, over 1000
// (RULE_06) clamp change to step limit
// (RULE_07) software sets step to 15% of entry four
// (RULE_08) ratio clamp is the last stage
// (RULE_09) growth capped at old times ratio over 10
// (RULE_10) shrink floored at old times ratio over 10
// (RULE_11) simulated resistance rises exponentially toward table
// (RULE_12) scaling starts at low charge or low voltage
// (RULE_13) scale recomputed every 30 seconds from resistance ratio
// (RULE_14) scale clamped between floor and ceiling
// (RULE_15) scaling only with its enable bit
// (RULE_16) thermal compensation off in region unless enabled
// (RULE_17) region uses its own load average choice
// (RULE_18) charge above thresholds resets scale
// (RULE_19) negative scale at initialization resets scale
// (RULE_20) warm open-circuit capture resets scale
// (RULE_21) unsigned truncating math, wide products
// (RULE_22) disqualified updates leave table untouched
module crs_scaler #(
  parameter int sec_cycles = crs_pkg::CLK_HZ
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        dsg_active,
  input  wire logic        chg_mode,
  input  wire logic [15:0] dsg_current,
  input  wire logic [15:0] design_capacity,
  input  wire logic [15:0] ocv_mv,
  input  wire logic [15:0] cell_mv,
  input  wire logic [15:0] terminate_mv,
  input  wire logic [7:0]  charge_level,
  input  wire logic [7:0]  temperature,
  input  wire logic        meas_valid,
  input  wire logic [3:0]  meas_index,
  input  wire logic [15:0] meas_res,
  input  wire logic [3:0]  soc_index,
  input  wire logic        init_pulse,
  input  wire logic [16:0] init_scale,
  input  wire logic        ocv_capture,
  input  wire logic        sim_start,
  input  wire logic [7:0]  normal_load_choice,
  output logic             commit_pulse,
  output logic             scaling_active,
  output logic      [15:0] scale_factor,
  output logic      [15:0] applied_res,
  output logic             thermal_comp_enable,
  output logic      [7:0]  load_average_choice
);
  localparam int SECW = $clog2(sec_cycles + 1);

  logic [7:0]  resistance_growth_ratio_limit;
  logic [7:0]  resistance_shrink_ratio_limit;
  logic [15:0] resistance_history_weight;
  logic [15:0] update_voltage_drop_threshold;
  logic [15:0] empty_region_voltage_margin;
  logic [15:0] resistance_rise_time_constant;
  logic [15:0] resistance_step_limit;
  logic [15:0] scale_factor_ceiling;
  logic [15:0] scale_factor_floor;
  logic [7:0]  scaling_start_charge_level;
  logic [7:0]  scaling_load_average_choice;
  logic [7:0]  scale_reset_temperature;
  logic [3:0]  ctrl;
  logic [15:0] cell_resistance_table [crs_pkg::ENTRIES];
  logic [15:0] work_res [crs_pkg::ENTRIES];

  // bus slave: one wait cycle so that hrdata comes from a flop
  logic       pend;
  logic       a_wr;
  logic [7:0] a_idx;
  logic [31:0] rd_mux;
  wire        ap_take = hsel && htrans[1] && hready;
  wire        sw_wr   = pend && a_wr;
  wire [3:0]  a_ent   = a_idx[3:0];
  wire        a_ent_ok = a_ent < 4'(crs_pkg::ENTRIES);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend      <= 1'b0;
      a_wr      <= 1'b0;
      a_idx     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (ap_take) begin
      pend      <= 1'b1;
      a_wr      <= hwrite;
      a_idx     <= haddr[9:2];
      hreadyout <= 1'b0;
    end else if (pend) begin
      pend      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= a_wr ? 32'h0000_0000 : rd_mux;
    end
  end

  function automatic logic hit(input logic [7:0] idx);
    hit = sw_wr && (a_idx == idx);
  endfunction : hit

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resistance_growth_ratio_limit <= crs_pkg::RST_GROW;
      resistance_shrink_ratio_limit <= crs_pkg::RST_SHRINK;
      resistance_history_weight     <= crs_pkg::RST_WEIGHT;
      update_voltage_drop_threshold <= crs_pkg::RST_VDROP;
      empty_region_voltage_margin   <= crs_pkg::RST_MARGIN;
      resistance_rise_time_constant <= crs_pkg::RST_RISE;
      resistance_step_limit         <= crs_pkg::RST_STEP;
      scale_factor_ceiling          <= crs_pkg::RST_CEIL;
      scale_factor_floor            <= crs_pkg::RST_FLOOR;
      scaling_start_charge_level    <= crs_pkg::RST_START;
      scaling_load_average_choice   <= crs_pkg::RST_LOAD;
      scale_reset_temperature       <= crs_pkg::RST_RSTTMP;
      ctrl                          <= crs_pkg::RST_CTRL;
    end else begin
      if (hit(crs_pkg::IDX_GROW))   resistance_growth_ratio_limit <= hwdata[7:0];
      if (hit(crs_pkg::IDX_SHRINK)) resistance_shrink_ratio_limit <= hwdata[7:0];
      if (hit(crs_pkg::IDX_WEIGHT)) resistance_history_weight <= hwdata[15:0];
      if (hit(crs_pkg::IDX_VDROP))  update_voltage_drop_threshold <= hwdata[15:0];
      if (hit(crs_pkg::IDX_MARGIN)) empty_region_voltage_margin <= hwdata[15:0];
      if (hit(crs_pkg::IDX_RISE))   resistance_rise_time_constant <= hwdata[15:0];
      if (hit(crs_pkg::IDX_STEP))   resistance_step_limit <= hwdata[15:0];
      if (hit(crs_pkg::IDX_CEIL))   scale_factor_ceiling <= hwdata[15:0];
      if (hit(crs_pkg::IDX_FLOOR))  scale_factor_floor <= hwdata[15:0];
      if (hit(crs_pkg::IDX_START))  scaling_start_charge_level <= hwdata[7:0];
      if (hit(crs_pkg::IDX_LOAD))   scaling_load_average_choice <= hwdata[7:0];
      if (hit(crs_pkg::IDX_RSTTMP)) scale_reset_temperature <= hwdata[7:0];
      if (hit(crs_pkg::IDX_CTRL))   ctrl <= hwdata[3:0];
    end
  end

  // one-second tick and discharge duration
  logic [SECW-1:0] sec_cnt;
  logic [15:0]     dsg_secs;
  logic [4:0]      scale_secs;
  wire sec_tick = sec_cnt == SECW'(sec_cycles - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt  <= '0;
      dsg_secs <= 16'h0000;
    end else begin
      sec_cnt <= sec_tick ? '0 : sec_cnt + SECW'(1);
      if (!dsg_active)
        dsg_secs <= 16'h0000;
      else if (sec_tick && dsg_secs != 16'hffff)
        dsg_secs <= dsg_secs + 16'h0001;
    end
  end

  // qualification
  wire meas_ok  = meas_valid && (meas_index < 4'(crs_pkg::ENTRIES));
  wire rate_ok  = (20'(dsg_current) * 20'(crs_pkg::RATE_DIV))
                  > 20'(design_capacity);
  wire drop_ok  = (ocv_mv > cell_mv) &&
                  ((ocv_mv - cell_mv) > update_voltage_drop_threshold);
  wire time_ok  = dsg_secs > 16'(crs_pkg::DSG_MIN_S);
  wire en_ok    = !ctrl[crs_pkg::CTRL_INHIBIT] && ctrl[crs_pkg::CTRL_GAUGE];
  wire commit_ok = (rate_ok || drop_ok) && time_ok && en_ok; // RULE_02 RULE_03 RULE_04

  // weighted blend, step limit, then ratio clamp, all unsigned
  wire [15:0] old_res = cell_resistance_table[meas_index];
  wire [9:0]  w_eff   = (resistance_history_weight > 16'(crs_pkg::WEIGHT_MAX))
                        ? crs_pkg::WEIGHT_MAX : resistance_history_weight[9:0];
  wire [26:0] w_sum   = 27'(old_res) * 27'(w_eff) +
                        27'(meas_res) * 27'(crs_pkg::WEIGHT_MAX - w_eff); // RULE_05 RULE_21
  wire [15:0] w_avg   = 16'(w_sum / 27'(crs_pkg::WEIGHT_MAX)); // RULE_05
  wire [16:0] up_lim  = 17'(old_res) + 17'(resistance_step_limit);
  wire [15:0] dn_lim  = (old_res > resistance_step_limit)
                        ? old_res - resistance_step_limit : 16'h0000;
  wire [15:0] step_v  = ({1'b0, w_avg} > up_lim) ? up_lim[15:0] :
                        (w_avg < dn_lim) ? dn_lim : w_avg; // RULE_06
  wire [23:0] hi_lim  = 24'(old_res) * 24'(resistance_growth_ratio_limit)
                        / 24'(crs_pkg::RATIO_DIV); // RULE_21
  wire [23:0] lo_lim  = 24'(old_res) * 24'(resistance_shrink_ratio_limit)
                        / 24'(crs_pkg::RATIO_DIV);
  wire [15:0] final_res =
    (step_v > old_res && 24'(step_v) > hi_lim) ? hi_lim[15:0] : // RULE_08 RULE_09
    (step_v < old_res && 24'(step_v) < lo_lim) ? lo_lim[15:0] : // RULE_10
    step_v;
  wire do_commit = meas_ok && commit_ok;

  generate
    for (genvar i = 0; i < crs_pkg::ENTRIES; i++) begin : g_ent
      wire sel  = meas_ok && meas_index == 4'(i);
      wire tswr = sw_wr && a_idx == {crs_pkg::TBL_PAGE, 4'(i)};
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cell_resistance_table[i] <= crs_pkg::RST_TBL;
          work_res[i]              <= 16'h0000;
        end else begin
          if (sel)
            work_res[i] <= meas_res; // RULE_01 RULE_22
          if (tswr)
            cell_resistance_table[i] <= hwdata[15:0];
          else if (sel && commit_ok)
            cell_resistance_table[i] <= final_res; // RULE_01
        end
      end
    end
  endgenerate

  // near-empty scaling
  wire [16:0] v_edge   = 17'(terminate_mv) + 17'(empty_region_voltage_margin);
  wire region = (charge_level <= scaling_start_charge_level) ||
                (17'(cell_mv) < v_edge); // RULE_12
  wire act_next = region && ctrl[crs_pkg::CTRL_SCALE]; // RULE_15
  wire chg_rst  = chg_mode && (17'(cell_mv) > v_edge) &&
                  (charge_level > scaling_start_charge_level); // RULE_18
  wire init_rst = init_pulse && init_scale[16]; // RULE_19
  wire ocv_rst  = ocv_capture && (temperature > scale_reset_temperature); // RULE_20
  wire [15:0] stored_r = cell_resistance_table[soc_index];
  wire [15:0] latest_r = work_res[soc_index];
  wire [25:0] raw_scl  = (stored_r == 16'h0000) ? 26'(scale_factor) :
                         26'(latest_r) * 26'(crs_pkg::UNITY) / 26'(stored_r);
  wire [25:0] raw_in   = raw_scl;
  function automatic logic [15:0] clampf(input logic [25:0] v);
    clampf = (v > 26'(scale_factor_ceiling)) ? scale_factor_ceiling :
             (v < 26'(scale_factor_floor)) ? scale_factor_floor : v[15:0];
  endfunction : clampf
  wire period_done = sec_tick &&
                     scale_secs == 5'(crs_pkg::SCALE_PERIOD_S - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scaling_active <= 1'b0;
      scale_secs     <= 5'h00;
      scale_factor   <= crs_pkg::UNITY;
    end else begin
      scaling_active <= act_next;
      if (!scaling_active)
        scale_secs <= 5'h00;
      else if (sec_tick)
        scale_secs <= period_done ? 5'h00 : scale_secs + 5'h01;
      if (chg_rst || init_rst || ocv_rst)
        scale_factor <= crs_pkg::UNITY; // RULE_18 RULE_19 RULE_20
      else if (init_pulse)
        scale_factor <= clampf(26'(init_scale[15:0])); // RULE_14
      else if (scaling_active && period_done)
        scale_factor <= clampf(raw_in); // RULE_13 RULE_14
    end
  end

  // transient resistance for discharge simulation, one step per second
  wire [31:0] tgt_w  = 32'(stored_r) * 32'(scale_factor)
                       / 32'(crs_pkg::UNITY);
  wire [15:0] target = (tgt_w > 32'h0000_ffff) ? 16'hffff : tgt_w[15:0];
  wire [15:0] gap_up = (target > applied_res) ? target - applied_res : 16'h0000;
  wire [15:0] gap_dn = (applied_res > target) ? applied_res - target : 16'h0000;
  wire [15:0] tau    = resistance_rise_time_constant;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_res         <= 16'h0000;
      commit_pulse        <= 1'b0;
      thermal_comp_enable <= 1'b1;
      load_average_choice <= crs_pkg::RST_LOAD;
    end else begin
      commit_pulse <= do_commit;
      if (sim_start)
        applied_res <= 16'h0000; // RULE_11
      else if (sec_tick && tau == 16'h0000)
        applied_res <= target;
      else if (sec_tick)
        applied_res <= applied_res + gap_up / tau - gap_dn / tau; // RULE_11
      thermal_comp_enable <= !act_next || ctrl[crs_pkg::CTRL_THERMAL]; // RULE_16
      load_average_choice <= act_next ? scaling_load_average_choice
                                      : normal_load_choice; // RULE_17
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (a_idx)
      crs_pkg::IDX_GROW:   rd_mux = 32'(resistance_growth_ratio_limit);
      crs_pkg::IDX_SHRINK: rd_mux = 32'(resistance_shrink_ratio_limit);
      crs_pkg::IDX_WEIGHT: rd_mux = 32'(resistance_history_weight);
      crs_pkg::IDX_VDROP:  rd_mux = 32'(update_voltage_drop_threshold);
      crs_pkg::IDX_MARGIN: rd_mux = 32'(empty_region_voltage_margin);
      crs_pkg::IDX_RISE:   rd_mux = 32'(resistance_rise_time_constant);
      crs_pkg::IDX_STEP:   rd_mux = 32'(resistance_step_limit);
      crs_pkg::IDX_CEIL:   rd_mux = 32'(scale_factor_ceiling);
      crs_pkg::IDX_FLOOR:  rd_mux = 32'(scale_factor_floor);
      crs_pkg::IDX_START:  rd_mux = 32'(scaling_start_charge_level);
      crs_pkg::IDX_LOAD:   rd_mux = 32'(scaling_load_average_choice);
      crs_pkg::IDX_RSTTMP: rd_mux = 32'(scale_reset_temperature);
      crs_pkg::IDX_CTRL:   rd_mux = 32'(ctrl);
      crs_pkg::IDX_STATUS: rd_mux = {30'h0000_0000, time_ok, scaling_active};
      crs_pkg::IDX_SCALE:  rd_mux = 32'(scale_factor);
      default: begin
        if (a_idx[7:4] == crs_pkg::TBL_PAGE && a_ent_ok)
          rd_mux = 32'(cell_resistance_table[a_ent]);
        else if (a_idx[7:4] == crs_pkg::WORK_PAGE && a_ent_ok)
          rd_mux = 32'(work_res[a_ent]);
      end
    endcase
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [15:0] chk_old;
  logic [15:0] chk_step;
  logic [3:0]  chk_idx;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_old  <= 16'h0000;
      chk_step <= 16'h0000;
      chk_idx  <= 4'h0;
    end else begin
      chk_old  <= old_res;
      chk_step <= resistance_step_limit;
      chk_idx  <= meas_index;
    end
  end
  wire [15:0] chk_new = cell_resistance_table[chk_idx];

  sequence s_commit_req;
    meas_ok && commit_ok && !sw_wr;
  endsequence
  sequence s_skip_req;
    meas_ok && !commit_ok && !sw_wr;
  endsequence

  chk_commit_qual: assert property ( // RULE_01
    commit_pulse && !$past(sw_wr)
      |-> $past(do_commit) && chk_new == $past(final_res))
    else $error("commit did not store the qualified value");
  chk_rate_or_drop: assert property ( // RULE_02
    commit_pulse |-> $past(rate_ok || drop_ok))
    else $error("commit without current or voltage drop");
  chk_dsg_time: assert property ( // RULE_03
    commit_pulse |-> $past(dsg_secs) > 16'(crs_pkg::DSG_MIN_S))
    else $error("commit before discharge time limit");
  chk_inhibit_gate: assert property ( // RULE_04
    (ctrl[crs_pkg::CTRL_INHIBIT] || !ctrl[crs_pkg::CTRL_GAUGE]) |=> !commit_pulse)
    else $error("commit while inhibited");
  chk_step_bound: assert property ( // RULE_06
    s_commit_req |=> (chk_new <= 17'(chk_old) + 17'(chk_step)) &&
                     (17'(chk_new) + 17'(chk_step) >= 17'(chk_old)))
    else $error("committed value exceeds step limit");
  chk_table_hold: assert property ( // RULE_22
    s_skip_req |=> chk_new == chk_old)
    else $error("table changed on disqualified update");
  chk_thermal_off: assert property ( // RULE_16
    act_next && !ctrl[crs_pkg::CTRL_THERMAL] |=> !thermal_comp_enable)
    else $error("thermal compensation left on in scaling region");
  chk_scale_reset: assert property ( // RULE_18
    chg_rst |=> scale_factor == crs_pkg::UNITY)
    else $error("scale not reset on charge recovery");
  chk_scale_hold: assert property ( // RULE_13
    scaling_active && !period_done && !init_pulse && !chg_rst && !ocv_rst
      |=> $stable(scale_factor))
    else $error("scale changed between periods");
  chk_inactive_hold: assert property ( // RULE_15
    !ctrl[crs_pkg::CTRL_SCALE] ##1 !ctrl[crs_pkg::CTRL_SCALE] |-> !scaling_active)
    else $error("scaling active while disabled");
endmodule : crs_scaler

/* hw/crs_pkg.sv */
// Purpose: constants for the cell resistance update and scaling block
// Assumes: AHB-Lite word registers, byte address = 4 * register index
// Notes:   single clock hclk at 40 MHz
package crs_pkg;
  // register indices
  localparam logic [7:0] IDX_GROW   = 8'h11;
  localparam logic [7:0] IDX_SHRINK = 8'h12;
  localparam logic [7:0] IDX_WEIGHT = 8'h14;
  localparam logic [7:0] IDX_VDROP  = 8'h16;
  localparam logic [7:0] IDX_MARGIN = 8'h42;
  localparam logic [7:0] IDX_RISE   = 8'h45;
  localparam logic [7:0] IDX_STEP   = 8'h5a;
  localparam logic [7:0] IDX_CEIL   = 8'h64;
  localparam logic [7:0] IDX_FLOOR  = 8'h66;
  localparam logic [7:0] IDX_START  = 8'h68;
  localparam logic [7:0] IDX_LOAD   = 8'h69;
  localparam logic [7:0] IDX_RSTTMP = 8'h6c;
  localparam logic [7:0] IDX_CTRL   = 8'h70;
  localparam logic [7:0] IDX_STATUS = 8'h71;
  localparam logic [7:0] IDX_SCALE  = 8'h72;
  localparam logic [3:0] TBL_PAGE   = 4'h8;
  localparam logic [3:0] WORK_PAGE  = 4'h9;
  // reset values
  localparam logic [7:0]  RST_GROW   = 8'h0f;
  localparam logic [7:0]  RST_SHRINK = 8'h05;
  localparam logic [15:0] RST_WEIGHT = 16'h0320;
  localparam logic [15:0] RST_VDROP  = 16'h0032;
  localparam logic [15:0] RST_MARGIN = 16'h00c8;
  localparam logic [15:0] RST_RISE   = 16'h01f4;
  localparam logic [15:0] RST_STEP   = 16'h0036;
  localparam logic [15:0] RST_CEIL   = 16'h1388;
  localparam logic [15:0] RST_FLOOR  = 16'h00c8;
  localparam logic [7:0]  RST_START  = 8'h0a;
  localparam logic [7:0]  RST_LOAD   = 8'h03;
  localparam logic [7:0]  RST_RSTTMP = 8'h0f;
  localparam logic [3:0]  RST_CTRL   = 4'h2;
  localparam logic [15:0] RST_TBL    = 16'h0000;
  // control bit positions
  localparam int CTRL_INHIBIT = 0;
  localparam int CTRL_GAUGE   = 1;
  localparam int CTRL_SCALE   = 2;
  localparam int CTRL_THERMAL = 3;
  // arithmetic constants
  localparam logic [15:0] UNITY      = 16'h03e8;
  localparam logic [9:0]  WEIGHT_MAX = 10'h3e8;
  localparam logic [4:0]  RATE_DIV   = 5'h0a;
  localparam logic [4:0]  RATIO_DIV  = 5'h0a;
  localparam int          ENTRIES    = 15;
  // times
  localparam int CLK_HZ         = 40_000_000;
  localparam int DSG_MIN_S      = 500;
  localparam int SCALE_PERIOD_S = 30;
endpackage : crs_pkg

/* bench/crs_scaler_tb.sv */
// Purpose: self-checking bench for resistance commit and near-empty scaler
// Assumes: one-second tick shortened to SEC hclk cycles
// Notes:   registers reached by single-word AHB-Lite transfers
module crs_scaler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 10;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp;
  logic        dsg_active = 0, chg_mode = 0, meas_valid = 0;
  logic        init_pulse = 0, ocv_capture = 0, sim_start = 0;
  logic [15:0] dsg_current = '0, design_capacity = 16'h03e8;
  logic [15:0] ocv_mv = 16'h0e10, cell_mv = 16'h0e10, meas_res = '0;
  logic [15:0] terminate_mv = 16'h0bb8;
  logic [7:0]  charge_level = 8'h32, temperature = 8'h14;
  logic [7:0]  normal_load_choice = 8'h05;
  logic [3:0]  meas_index = '0, soc_index = 4'h2;
  logic [16:0] init_scale = '0;
  logic        commit_pulse, scaling_active, thermal_comp_enable;
  logic [15:0] scale_factor, applied_res;
  logic [7:0]  load_average_choice;
  int          miscompares = 0, cmp_count = 0;
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  crs_scaler #(.sec_cycles(SEC)) i_crs_scaler (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .dsg_active, .chg_mode,
    .dsg_current, .design_capacity, .ocv_mv, .cell_mv, .terminate_mv,
    .charge_level, .temperature, .meas_valid, .meas_index, .meas_res,
    .soc_index, .init_pulse, .init_scale, .ocv_capture, .sim_start,
    .normal_load_choice, .commit_pulse, .scaling_active, .scale_factor,
    .applied_res, .thermal_comp_enable, .load_average_choice
  );
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // one transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] ix,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, ix, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ix, d, x);
  endtask : wr
  task automatic rdc(input logic [7:0] ix, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, ix, 32'h0, x);
    check($sformatf("reg %h", ix), e, x);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : rdc
  // pulse one measurement for entry 2, look at the pulse a cycle later
  task automatic meas(input logic [15:0] r, input logic e);
    @(posedge hclk);
    meas_index <= 4'h2;
    meas_res   <= r;
    meas_valid <= 1'b1;
    @(posedge hclk);
    meas_valid <= 1'b0;
    @(posedge hclk);
    check("commit_pulse", {31'h0, e}, {31'h0, commit_pulse});
  endtask : meas
  task automatic t_regs;
    logic [7:0]  ix [12] = '{8'h11, 8'h12, 8'h14, 8'h16, 8'h42, 8'h45,
                             8'h5a, 8'h64, 8'h66, 8'h68, 8'h69, 8'h6c};
    logic [15:0] rv [12] = '{16'h000f, 16'h0005, 16'h0320, 16'h0032,
                             16'h00c8, 16'h01f4, 16'h0036, 16'h1388,
                             16'h00c8, 16'h000a, 16'h0003, 16'h000f};
    foreach (ix[i]) rdc(ix[i], {16'h0, rv[i]});
    wr(8'h11, 32'h0000_00aa);
    rdc(8'h11, 32'h0000_00aa);
    wr(8'h7f, 32'h0000_1234);
    rdc(8'h7f, 32'h0000_0000);
    wr(8'h11, 32'h0000_000f);
    rdc(8'h70, 32'h0000_0002);
    rdc(8'h72, 32'h0000_03e8);
    wr(8'h84, 32'h0000_0168);
    wr(8'h5a, 32'h0000_0036);
  endtask : t_regs
  task automatic t_commit;
    wr(8'h82, 32'h0000_0064);
    dsg_active  <= 1'b1;
    dsg_current <= 16'h00c8;
    meas(16'h00c8, 1'b0);
    rdc(8'h82, 32'h0000_0064);
    rdc(8'h92, 32'h0000_00c8);
    repeat (510 * SEC) @(posedge hclk);
    meas(16'h00c8, 1'b1);
    rdc(8'h82, 32'h0000_0078);
    wr(8'h5a, 32'h0000_000a);
    meas(16'h00c8, 1'b1);
    rdc(8'h82, 32'h0000_0082);
    wr(8'h5a, 32'h0000_7fff);
    wr(8'h14, 32'h0000_0000);
    meas(16'h0190, 1'b1);
    rdc(8'h82, 32'h0000_00c3);
    meas(16'h000a, 1'b1);
    rdc(8'h82, 32'h0000_0061);
    dsg_current <= 16'h0064; // exactly capacity/10 is not enough
    meas(16'h0061, 1'b0);
    cell_mv <= 16'h0ddd;
    meas(16'h0061, 1'b1);
    wr(8'h70, 32'h0000_0003);
    meas(16'h003c, 1'b0);
    wr(8'h70, 32'h0000_0000);
    meas(16'h003c, 1'b0);
    rdc(8'h82, 32'h0000_0061);
    rdc(8'h92, 32'h0000_003c);
    rdc(8'h71, 32'h0000_0002);
    cell_mv <= 16'h0e10;
  endtask : t_commit
  task automatic t_scale;
    wr(8'h70, 32'h0000_0006);
    repeat (3) @(posedge hclk);
    check("idle", 32'h0, {31'h0, scaling_active});
    charge_level <= 8'h0a;
    repeat (3) @(posedge hclk);
    check("active", 32'h1, {31'h0, scaling_active});
    check("thermal", 32'h0, {31'h0, thermal_comp_enable});
    check("load", 32'h3, {24'h0, load_average_choice});
    repeat (32 * SEC) @(posedge hclk);
    check("scale", 32'h0000_026a, {16'h0, scale_factor});
    init_scale <= 17'h0_012c;
    init_pulse <= 1'b1;
    @(posedge hclk);
    init_pulse <= 1'b0;
    repeat (2) @(posedge hclk);
    check("init", 32'h0000_012c, {16'h0, scale_factor});
    init_scale <= 17'h1_012c;
    init_pulse <= 1'b1;
    @(posedge hclk);
    init_pulse <= 1'b0;
    repeat (2) @(posedge hclk);
    check("neg", 32'h0000_03e8, {16'h0, scale_factor});
    temperature <= 8'h0f;
    ocv_capture <= 1'b1;
    @(posedge hclk);
    ocv_capture <= 1'b0;
    repeat (2) @(posedge hclk);
    wr(8'h66, 32'h0000_02bc);
    repeat (30 * SEC) @(posedge hclk);
    check("floor", 32'h0000_02bc, {16'h0, scale_factor});
    temperature <= 8'h10;
    ocv_capture <= 1'b1;
    @(posedge hclk);
    ocv_capture <= 1'b0;
    repeat (2) @(posedge hclk);
    check("ocv", 32'h0000_03e8, {16'h0, scale_factor});
    wr(8'h70, 32'h0000_000e);
    charge_level <= 8'h32;
    cell_mv      <= 16'h0c7f;
    repeat (3) @(posedge hclk);
    check("vmargin", 32'h1, {31'h0, scaling_active});
    check("thermal on", 32'h1, {31'h0, thermal_comp_enable});
    cell_mv <= 16'h0c80;
    repeat (3) @(posedge hclk);
    check("vedge", 32'h0, {31'h0, scaling_active});
    check("load out", 32'h5, {24'h0, load_average_choice});
    wr(8'h45, 32'h0000_0000);
    sim_start <= 1'b1;
    @(posedge hclk);
    sim_start <= 1'b0;
    repeat (3 * SEC) @(posedge hclk);
    check("applied", 32'h0000_0061, {16'h0, applied_res});
    init_scale <= 17'h0_012c;
    init_pulse <= 1'b1;
    @(posedge hclk);
    init_pulse <= 1'b0;
    chg_mode     <= 1'b1;
    charge_level <= 8'h0b;
    cell_mv      <= 16'h0c81;
    repeat (3) @(posedge hclk);
    check("chg", 32'h0000_03e8, {16'h0, scale_factor});
  endtask : t_scale
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_commit();
    t_scale();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    end_sim();
  end
endmodule : crs_scaler_tb
